// file: core/btsp_pkg.sv
// Purpose: Constants, register map and state type for the byte timer
//          with shared prescaler.
// Assumes: One 100 MHz clock; an instruction cycle is four clock cycles.
// Notes:   Register offsets are indexes; byte address is four times the index.
//
// Summary of operation
// - Clock select clear: timer mode, one increment per instruction cycle with the prescaler on the watchdog.
// - A counter write blocks increments for the next two instruction cycles.
// - Clock select set: count pin edges; edge bit clear rising, set falling.
// - The count pin is synchronised first, so counted edges arrive late.
// - One 8-bit prescaler, given to the counter or the watchdog, never both.
// - Software can neither read nor write the prescaler count.
// - Assignment bit and 3-bit ratio sit in option register bits 3:0.
// - Assignment clear: prescaler feeds counter, ratio 1:2 to 1:256.
// - Assignment set: prescaler follows watchdog, ratio 1:1 to 1:128.
// - Counter writes clear the prescaler when it belongs to the counter.
// - Watchdog clear clears prescaler and watchdog when assigned to watchdog.
// - Software may change the assignment at any time, counter running.
// - A wrap from FFh to 00h sets the overflow flag, control bit 2.
// - Overflow request raised only while enable bit 5 is set.
// - Counter halts in sleep, so no overflow wakes the processor.

package btsp_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_TIMER_COUNT  = 8'h01;
  localparam logic [7:0] IDX_INTR_CONTROL = 8'h0B;
  localparam logic [7:0] IDX_OPTION       = 8'h81;
  localparam int         ADDR_IDX_LSB     = 2;
  localparam int         ADDR_IDX_MSB     = 9;

  // ---------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------
  localparam int         OPT_CS_BIT       = 5;
  localparam int         OPT_EDGE_BIT     = 4;
  localparam int         OPT_ASSIGN_BIT   = 3;
  localparam int         OPT_RATIO_LSB    = 0;
  localparam int         RATIO_W          = 3;
  localparam int         IC_FLAG_BIT      = 2;
  localparam int         IC_EN_BIT        = 5;
  localparam logic [7:0] OPTION_RST       = 8'hFF;
  localparam logic [7:0] INTR_CONTROL_RST = 8'h00;
  localparam logic [7:0] COUNT_RST        = 8'h00;
  localparam logic [7:0] PRE_RST          = 8'h00;
  localparam logic [7:0] COUNT_MAX        = 8'hFF;
  localparam logic [2:0] RATIO_MIN        = 3'h0;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int         CLK_PERIOD_NS    = 10;
  localparam int         INSTR_PERIOD_NS  = 40;
  localparam int         PHASES_PER_INSTR = INSTR_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [1:0] PHASE_RST        = 2'h0;
  localparam logic [1:0] PHASE_LAST       = 2'(PHASES_PER_INSTR - 1);
  localparam logic [1:0] INHIBIT_CYCLES   = 2'h2;
  localparam logic [1:0] INHIBIT_NONE     = 2'h0;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] phase;
    logic [1:0] inhibit;
    logic       sync1;
    logic       sync2;
    logic       sync3;
    logic [7:0] pre;
    logic [7:0] count;
    logic [7:0] interrupt_control;
    logic [7:0] option;
    logic       wdt_clr;
    logic       wdt_out;
    logic       dp_valid;
    logic       dp_write;
    logic [7:0] dp_idx;
  } btsp_state_t;

  localparam btsp_state_t STATE_RST = '{
    phase: PHASE_RST, inhibit: INHIBIT_NONE, sync1: 1'b0, sync2: 1'b0,
    sync3: 1'b0, pre: PRE_RST, count: COUNT_RST, interrupt_control: INTR_CONTROL_RST,
    option: OPTION_RST, wdt_clr: 1'b0, wdt_out: 1'b0, dp_valid: 1'b0,
    dp_write: 1'b0, dp_idx: 8'h00};

endpackage : btsp_pkg

// file: core/btsp_timer.sv
// Purpose: 8-bit timer/counter with shared 8-bit prescaler, AHB-Lite slave.
// Assumes: Pins synchronous to clk_sys; single word AHB transfers only.
// Notes:   Slave never waits; unmapped reads give zero, writes are dropped.
`timescale 1ns/1ns

module btsp_timer
  import btsp_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        external_count_input,
  input  wire logic        sleep_active,
  input  wire logic        watchdog_clear_instr,
  input  wire logic        wdt_base_tick,
  output logic             wdt_scaled_tick,
  output logic             wdt_clear,
  output logic             overflow_irq
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Low bits all ones means the division period is complete
  function automatic logic [7:0] ratio_mask(input logic [2:0] r,
                                            input logic       extra);
    logic [8:0] t;
    t = 9'h001 << ({1'b0, r} + {3'h0, extra});
    return 8'(t - 9'h001);
  endfunction : ratio_mask

  btsp_state_t s_q;
  btsp_state_t s_d;

  logic       ap_take;
  logic       wr_hit;
  logic       tc_wr;
  logic       ic_wr;
  logic       op_wr;
  logic [7:0] wr_byte;
  logic [7:0] rd_byte;
  logic       src_ext;
  logic       edge_inv;
  logic       to_wdt;
  logic [2:0] ratio;
  logic       instr_tick;
  logic       edge_evt;
  logic       src_tick;
  logic       src_go;
  logic       pre_tick;
  logic [7:0] pre_mask;
  logic       pre_full;
  logic       cnt_inc;
  logic       ovf;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  assign ap_take = hsel && htrans[1] && hready;
  assign wr_byte = hwdata[7:0];
  assign wr_hit  = s_q.dp_valid && s_q.dp_write;
  assign tc_wr   = wr_hit && (s_q.dp_idx == IDX_TIMER_COUNT);
  assign ic_wr   = wr_hit && (s_q.dp_idx == IDX_INTR_CONTROL);
  assign op_wr   = wr_hit && (s_q.dp_idx == IDX_OPTION);

  // No index reaches the prescaler, so it stays hidden from software
  assign rd_byte = (s_q.dp_idx == IDX_TIMER_COUNT)  ? s_q.count  :
                   (s_q.dp_idx == IDX_INTR_CONTROL) ? s_q.interrupt_control :
                   (s_q.dp_idx == IDX_OPTION)       ? s_q.option : 8'h00;
  assign hrdata    = (s_q.dp_valid && !s_q.dp_write) ? {24'h000000, rd_byte}
                                                     : 32'h00000000;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ---------------------------------------------------------------
  // Count path
  // ---------------------------------------------------------------
  // Fields are used live, so reassignment takes effect at once
  assign src_ext    = s_q.option[OPT_CS_BIT];
  assign edge_inv   = s_q.option[OPT_EDGE_BIT];
  assign to_wdt     = s_q.option[OPT_ASSIGN_BIT];
  assign ratio      = s_q.option[OPT_RATIO_LSB +: RATIO_W];
  assign instr_tick = (s_q.phase == PHASE_LAST);

  // Edge taken after the two-stage synchroniser: two cycles of latency
  assign edge_evt = (s_q.sync2 ^ edge_inv) && !(s_q.sync3 ^ edge_inv);
  assign src_tick = src_ext ? edge_evt : instr_tick;
  assign src_go   = src_tick && !sleep_active
                    && (s_q.inhibit == INHIBIT_NONE);

  // One prescaler, its input and output steered by the assignment bit
  assign pre_tick = to_wdt ? wdt_base_tick : src_go;
  assign pre_mask = to_wdt ? ratio_mask(ratio, 1'b0)
                           : ratio_mask(ratio, 1'b1);
  assign pre_full = pre_tick && ((s_q.pre & pre_mask) == pre_mask);
  assign cnt_inc  = to_wdt ? src_go : pre_full;
  assign ovf      = cnt_inc && (s_q.count == COUNT_MAX);

  // Flag and enable both come from flops, so the request is glitch free
  assign overflow_irq    = s_q.interrupt_control[IC_FLAG_BIT]
                           && s_q.interrupt_control[IC_EN_BIT];
  assign wdt_scaled_tick = s_q.wdt_out;
  assign wdt_clear       = s_q.wdt_clr;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d          = s_q;
    s_d.phase    = s_q.phase + 2'h1;
    s_d.sync1    = external_count_input;
    s_d.sync2    = s_q.sync1;
    s_d.sync3    = s_q.sync2;
    s_d.dp_valid = ap_take && (haddr[31:ADDR_IDX_MSB+1] == '0);
    s_d.dp_write = hwrite;
    s_d.dp_idx   = haddr[ADDR_IDX_MSB:ADDR_IDX_LSB];
    s_d.wdt_clr  = watchdog_clear_instr;
    s_d.wdt_out  = to_wdt ? pre_full : wdt_base_tick;

    if (pre_tick) begin
      s_d.pre = s_q.pre + 8'h01;
    end
    if (tc_wr && !to_wdt) begin
      s_d.pre = PRE_RST;
    end
    if (watchdog_clear_instr && to_wdt) begin
      s_d.pre = PRE_RST;
    end

    if (tc_wr) begin
      s_d.inhibit = INHIBIT_CYCLES;
    end else if (instr_tick && s_q.inhibit != INHIBIT_NONE) begin
      s_d.inhibit = s_q.inhibit - 2'h1;
    end

    // Wraps to zero and keeps running; a write wins over the increment
    if (tc_wr) begin
      s_d.count = wr_byte;
    end else if (cnt_inc) begin
      s_d.count = s_q.count + 8'h01;
    end

    if (ic_wr) begin
      s_d.interrupt_control = wr_byte;
    end
    // Set after the write so an overflow is never lost to a clear
    if (ovf) begin
      s_d.interrupt_control[IC_FLAG_BIT] = 1'b1;
    end

    if (op_wr) begin
      s_d.option = wr_byte;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  property p_timer_mode;
    !src_ext && to_wdt && !sleep_active && instr_tick && !tc_wr
      && s_q.inhibit == INHIBIT_NONE
      |=> s_q.count == 8'($past(s_q.count) + 8'h01);
  endproperty
  a_timer_mode: assert property (p_timer_mode)
    else $error("timer mode did not advance on instruction cycle");

  property p_write_inhibit;
    tc_wr |=> !cnt_inc [*5];
  endproperty
  a_write_inhibit: assert property (p_write_inhibit)
    else $error("counter advanced during write inhibit");

  property p_ext_rise;
    (src_ext && !edge_inv && !external_count_input)
      ##1 (src_ext && !edge_inv && external_count_input)
      |=> ##1 (edge_evt || $past(op_wr));
  endproperty
  a_ext_rise: assert property (p_ext_rise)
    else $error("synchronised rising edge not seen two cycles later");

  property p_ratio_bit;
    !to_wdt && cnt_inc |-> s_q.pre[ratio];
  endproperty
  a_ratio_bit: assert property (p_ratio_bit)
    else $error("counter advanced before division period completed");

  property p_wdt_unity;
    to_wdt && ratio == RATIO_MIN && wdt_base_tick |=> wdt_scaled_tick;
  endproperty
  a_wdt_unity: assert property (p_wdt_unity)
    else $error("watchdog 1:1 tick missing");

  property p_pre_clr_write;
    tc_wr && !to_wdt |=> s_q.pre == PRE_RST;
  endproperty
  a_pre_clr_write: assert property (p_pre_clr_write)
    else $error("prescaler not cleared by counter write");

  property p_pre_clr_wdt;
    watchdog_clear_instr && to_wdt |=> s_q.pre == PRE_RST && wdt_clear;
  endproperty
  a_pre_clr_wdt: assert property (p_pre_clr_wdt)
    else $error("watchdog clear did not clear prescaler");

  property p_ovf_flag;
    ovf |=> s_q.interrupt_control[IC_FLAG_BIT] && (s_q.count == COUNT_RST || $past(tc_wr));
  endproperty
  a_ovf_flag: assert property (p_ovf_flag)
    else $error("wrap did not set overflow flag");

  property p_irq_mask;
    s_q.interrupt_control[IC_FLAG_BIT] |-> overflow_irq == s_q.interrupt_control[IC_EN_BIT];
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("overflow request disagrees with enable");

  property p_sleep_halt;
    sleep_active && !tc_wr |=> s_q.count == $past(s_q.count);
  endproperty
  a_sleep_halt: assert property (p_sleep_halt)
    else $error("counter moved during sleep");

  property p_set_wins;
    ovf && ic_wr |=> s_q.interrupt_control[IC_FLAG_BIT];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("flag clear beat a same-cycle overflow");

  property p_ext_fall;
    (src_ext && edge_inv && external_count_input)
      ##1 (src_ext && edge_inv && !external_count_input)
      |=> ##1 (edge_evt || $past(op_wr));
  endproperty
  a_ext_fall: assert property (p_ext_fall)
    else $error("synchronised falling edge not seen two cycles later");

  // A falling pin must never count while rising edges are selected
  property p_rise_only;
    (src_ext && !edge_inv && external_count_input)
      ##1 (src_ext && !edge_inv && !external_count_input)
      |=> ##1 (!edge_evt || $past(op_wr));
  endproperty
  a_rise_only: assert property (p_rise_only)
    else $error("falling edge counted in rising edge mode");

  property p_inhibit_load;
    tc_wr |=> s_q.inhibit == INHIBIT_CYCLES;
  endproperty
  a_inhibit_load: assert property (p_inhibit_load)
    else $error("counter write did not start the inhibit window");

  property p_unmapped_zero;
    s_q.dp_valid && !s_q.dp_write && s_q.dp_idx != IDX_TIMER_COUNT
      && s_q.dp_idx != IDX_INTR_CONTROL && s_q.dp_idx != IDX_OPTION
      |-> hrdata == 32'h00000000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read returned nonzero data");

  property p_pre_sleep;
    !to_wdt && sleep_active && !tc_wr |=> s_q.pre == $past(s_q.pre);
  endproperty
  a_pre_sleep: assert property (p_pre_sleep)
    else $error("prescaler moved during sleep");

  property p_flag_sticky;
    s_q.interrupt_control[IC_FLAG_BIT] && !ic_wr |=> s_q.interrupt_control[IC_FLAG_BIT];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("overflow flag cleared without a software write");

  property p_wrap_zero;
    ovf && !tc_wr |=> s_q.count == COUNT_RST;
  endproperty
  a_wrap_zero: assert property (p_wrap_zero)
    else $error("counter did not wrap to zero");

  property p_wdt_bypass;
    !to_wdt && wdt_base_tick |=> wdt_scaled_tick;
  endproperty
  a_wdt_bypass: assert property (p_wdt_bypass)
    else $error("watchdog tick lost while prescaler is on the counter");

  property p_wdt_clear_pulse;
    watchdog_clear_instr |=> wdt_clear;
  endproperty
  a_wdt_clear_pulse: assert property (p_wdt_clear_pulse)
    else $error("watchdog clear not passed on");

  c_overflow:  cover property (ovf && s_q.interrupt_control[IC_EN_BIT]);
  c_write_inc: cover property (tc_wr ##[1:16] cnt_inc);
  c_ext_count: cover property (src_ext && edge_evt && cnt_inc);
  c_wdt_scale: cover property (to_wdt && ratio != RATIO_MIN && wdt_scaled_tick);
  c_set_wins:  cover property (ovf && ic_wr);

endmodule : btsp_timer

// file: tb/btsp_pulse_src.sv
// Purpose: Far-side model that drives the external count pin.
// Assumes: Levels change just after a rising edge of clk_sys.
// Notes:   Each level is held at least 5 clocks, longer than the two-flop sync.
`timescale 1ns/1ns

module btsp_pulse_src (
  input  wire logic clk_sys,
  output logic      pin
);
  // -----
  // Pin driver
  // -----
  initial pin = 1'h0;

  // Short levels would be lost in the synchroniser, so hold each one
  task automatic set_level(input logic lvl);
    @(posedge clk_sys);
    pin <= lvl;
    repeat (4) @(posedge clk_sys);
  endtask : set_level

  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      set_level(1'h1);
      set_level(1'h0);
    end
  endtask : pulses
endmodule : btsp_pulse_src

// file: tb/byte_timer_shared_prescaler_test.sv
// Purpose: Self-checking bench for the byte timer with shared prescaler.
// Assumes: Slave answers through hreadyout; pin model holds levels at least 5 clocks.
// Notes:   Phase runs free, so rates are judged within a window.
`timescale 1ns/1ns

module byte_timer_shared_prescaler_test;
  import btsp_pkg::*;
  localparam logic [31:0] A_CNT = {22'h0, IDX_TIMER_COUNT, 2'h0};
  localparam logic [31:0] A_IC  = {22'h0, IDX_INTR_CONTROL, 2'h0};
  localparam logic [31:0] A_OPT = {22'h0, IDX_OPTION, 2'h0};
  localparam int          LIMIT = 20000;
  logic        clk_sys, sys_rst, hsel, hwrite, hready, hresp, sleep_active;
  logic        watchdog_clear_instr, wdt_base_tick, wdt_scaled_tick, wdt_clear;
  logic        overflow_irq, ext_pin;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  int          bad_count, checked, cyc, n_tick, n_clr;

  btsp_timer DUT (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .external_count_input(ext_pin), .sleep_active(sleep_active),
    .watchdog_clear_instr(watchdog_clear_instr), .wdt_base_tick(wdt_base_tick),
    .wdt_scaled_tick(wdt_scaled_tick), .wdt_clear(wdt_clear),
    .overflow_irq(overflow_irq));

  btsp_pulse_src src (.clk_sys(clk_sys), .pin(ext_pin));

  // -----
  // Helpers
  // -----
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", w, e, g);
    end
  endtask : chk

  task automatic in_rng(input string w, input logic [7:0] lo, input logic [7:0] hi);
    checked++;
    if ((rdv[7:0] >= lo && rdv[7:0] <= hi) !== 1'h1) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h..%0h seen %0h", w, lo, hi, rdv);
    end
  endtask : in_rng

  // Address phase held until hready, data phase likewise
  task automatic bus(input logic wr, input logic [31:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk_sys); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clk_sys); while (hready !== 1'h1);
    rdv = hrdata;
  endtask : bus

  task automatic rd_chk(input string w, input logic [31:0] a, input logic [31:0] e);
    bus(1'h0, a, 8'h00);
    chk(w, e, rdv);
  endtask : rd_chk

  task automatic strobe(input logic clr, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      watchdog_clear_instr <= clr;
      wdt_base_tick <= ~clr;
      @(posedge clk_sys);
      watchdog_clear_instr <= 1'h0;
      wdt_base_tick <= 1'h0;
      repeat (2) @(posedge clk_sys);
    end
  endtask : strobe

  // -----
  // Scenarios
  // -----
  task automatic t_reset;
    rd_chk("option", A_OPT, 32'hFF);
    rd_chk("count", A_CNT, 32'h0);
    rd_chk("interrupt_control", A_IC, 32'h0);
    rd_chk("unmapped", 32'h8, 32'h0);
    rd_chk("high addr", 32'h1004, 32'h0);
    chk("hresp", 32'h0, {31'h0, hresp});
    $display("done reset");
  endtask : t_reset

  task automatic t_timer;
    bus(1'h1, A_OPT, 8'h08);
    bus(1'h1, A_CNT, 8'h00);
    rd_chk("count held", A_CNT, 32'h0);
    repeat (100) @(posedge clk_sys);
    bus(1'h0, A_CNT, 8'h00);
    in_rng("timer rate", 8'h16, 8'h1A);
    $display("done timer");
  endtask : t_timer

  task automatic t_presc;
    for (int r = 0; r < 3; r++) begin
      bus(1'h1, A_OPT, 8'(r));
      bus(1'h1, A_CNT, 8'h00);
      repeat (256) @(posedge clk_sys);
      bus(1'h0, A_CNT, 8'h00);
      in_rng("prescaled", (8'h20 >> r) - 8'h02, 8'h20 >> r);
    end
    $display("done prescaler");
  endtask : t_presc

  task automatic t_count;
    bus(1'h1, A_OPT, 8'h28);
    bus(1'h1, A_CNT, 8'h00);
    repeat (10) @(posedge clk_sys);
    src.set_level(1'h1);
    src.set_level(1'h0);
    src.pulses(3);
    rd_chk("rising", A_CNT, 32'h4);
    bus(1'h1, A_OPT, 8'h38);
    bus(1'h1, A_CNT, 8'h00);
    repeat (10) @(posedge clk_sys);
    src.set_level(1'h1);
    rd_chk("no falling", A_CNT, 32'h0);
    src.set_level(1'h0);
    rd_chk("falling", A_CNT, 32'h1);
    $display("done counter");
  endtask : t_count

  task automatic t_sleep;
    bus(1'h1, A_OPT, 8'h08);
    sleep_active <= 1'h1;
    bus(1'h1, A_CNT, 8'h55);
    repeat (60) @(posedge clk_sys);
    rd_chk("asleep", A_CNT, 32'h55);
    sleep_active <= 1'h0;
    repeat (40) @(posedge clk_sys);
    bus(1'h0, A_CNT, 8'h00);
    in_rng("awake", 8'h57, 8'h60);
    $display("done sleep");
  endtask : t_sleep

  task automatic t_ovf;
    bus(1'h1, A_IC, 8'h20);
    bus(1'h1, A_CNT, 8'hFC);
    repeat (40) @(posedge clk_sys);
    rd_chk("flag set", A_IC, 32'h24);
    chk("irq", 32'h1, {31'h0, overflow_irq});
    bus(1'h0, A_CNT, 8'h00);
    in_rng("after wrap", 8'h03, 8'h0A);
    bus(1'h1, A_IC, 8'h04);
    repeat (2) @(posedge clk_sys);
    chk("irq masked", 32'h0, {31'h0, overflow_irq});
    bus(1'h1, A_IC, 8'h00);
    rd_chk("flag clear", A_IC, 32'h0);
    $display("done overflow");
  endtask : t_ovf

  // Pin edge timed so the wrap falls in the data phase of a flag clear
  task automatic t_race;
    bus(1'h1, A_OPT, 8'h28);
    bus(1'h1, A_CNT, 8'hFF);
    repeat (10) @(posedge clk_sys);
    fork
      src.set_level(1'h1);
      begin
        @(posedge clk_sys);
        bus(1'h1, A_IC, 8'h00);
      end
    join
    rd_chk("set wins", A_IC, 32'h4);
    rd_chk("wrapped", A_CNT, 32'h0);
    bus(1'h1, A_IC, 8'h00);
    $display("done race");
  endtask : t_race

  task automatic t_wdt;
    int base;
    int clr0;
    bus(1'h1, A_CNT, 8'h00);
    bus(1'h1, A_OPT, 8'h0A);
    base = n_tick;
    clr0 = n_clr;
    strobe(1'h1, 1);
    strobe(1'h0, 3);
    strobe(1'h1, 1);
    strobe(1'h0, 3);
    chk("after clear", base, n_tick);
    strobe(1'h0, 1);
    chk("ratio 4", base + 1, n_tick);
    chk("clears", 32'h2, n_clr - clr0);
    bus(1'h1, A_OPT, 8'h08);
    strobe(1'h0, 4);
    chk("ratio 1", base + 5, n_tick);
    bus(1'h1, A_OPT, 8'h00);
    strobe(1'h0, 2);
    chk("unscaled", base + 7, n_tick);
    $display("done watchdog");
  endtask : t_wdt

  // -----
  // Clock, watchdog and timeout
  // -----
  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (wdt_scaled_tick === 1'h1) n_tick++;
    if (wdt_clear === 1'h1) n_clr++;
    if (cyc == LIMIT) begin
      bad_count++;
      test_done;
    end
  end

  initial begin
    sys_rst = 1'h1;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    sleep_active = 1'h0;
    watchdog_clear_instr = 1'h0;
    wdt_base_tick = 1'h0;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'h0;
    t_reset;
    t_timer;
    t_presc;
    t_count;
    t_sleep;
    t_ovf;
    t_race;
    t_wdt;
    test_done;
  end
endmodule : byte_timer_shared_prescaler_test
